// File: logic/flqt_map.svh
// Purpose: offsets, field positions, reset values and table contents of the query table block
// Assumes: every query location sits at a word index; its byte address is four times that index
// Notes:   definitions only
`ifndef FLQT_MAP_SVH
`define FLQT_MAP_SVH

// query location indices (byte address = index * 4)
`define FLQT_LOC_PTR_LO     7'h15
`define FLQT_LOC_PTR_HI     7'h16
`define FLQT_LOC_ID_P       7'h39
`define FLQT_LOC_ID_R       7'h3a
`define FLQT_LOC_ID_I       7'h3b
`define FLQT_LOC_MAJOR      7'h3c
`define FLQT_LOC_MINOR      7'h3d
`define FLQT_LOC_FEAT0      7'h3e
`define FLQT_LOC_FEAT1      7'h3f
`define FLQT_LOC_FEAT2      7'h40
`define FLQT_LOC_FEAT3      7'h41
`define FLQT_LOC_SUSP       7'h42
`define FLQT_LOC_PROT_LO    7'h43
`define FLQT_LOC_PROT_HI    7'h44
`define FLQT_LOC_VDD_OPT    7'h45
`define FLQT_LOC_VPP_OPT    7'h46
`define FLQT_LOC_PR_COUNT   7'h47
`define FLQT_LOC_PR_ADDR_LO 7'h48
`define FLQT_LOC_PR_ADDR_HI 7'h49
`define FLQT_LOC_PR_FACT    7'h4a
`define FLQT_LOC_PR_USER    7'h4b

// table contents
`define FLQT_VAL_PTR_LO     16'h0039
`define FLQT_VAL_ID_P       16'h0050
`define FLQT_VAL_ID_R       16'h0052
`define FLQT_VAL_ID_I       16'h0049
`define FLQT_VAL_MAJOR      16'h0031
`define FLQT_VAL_MINOR      16'h0030
`define FLQT_VAL_FEAT0      16'h00e6
`define FLQT_VAL_FEAT1      16'h0003
`define FLQT_VAL_SUSP       16'h0001
`define FLQT_VAL_PROT_LO    16'h0003
`define FLQT_VAL_VDD_OPT    16'h0018
`define FLQT_VAL_VPP_OPT    16'h00c0
`define FLQT_VAL_PR_COUNT   16'h0001
`define FLQT_VAL_PR_ADDR_LO 16'h0080
`define FLQT_VAL_PR_FACT    16'h0003
`define FLQT_VAL_PR_USER    16'h0004
`define FLQT_VAL_ZERO       16'h0000

// block's own registers (byte addresses)
`define FLQT_ADDR_CTRL      12'h300
`define FLQT_ADDR_STAT      12'h304
`define FLQT_QUERY_TOP      12'h1fc
`define FLQT_CTRL_QEN_BIT   0
`define FLQT_CTRL_RESET     1'b0
`define FLQT_STAT_QEN_BIT   16
`endif

// File: logic/flqt_pkg.sv
// Purpose: types shared by the query table block
// Assumes: 12-bit apb byte address
// Notes:   constants live in flqt_map.svh
package flqt_pkg;
    typedef logic [11:0] flqt_addr_t;   // apb byte address
    typedef logic [15:0] flqt_word_t;   // one query word

    // one apb request as seen by the slave
    typedef struct packed {
        logic       sel;
        logic       en;
        logic       wr;
        flqt_addr_t addr;
        logic [31:0] wdata;
        logic [3:0] strb;
    } flqt_apb_req_s;

    // transfer phase, gray along idle -> answer
    typedef enum logic [1:0] {
        FLQT_IDLE   = 2'b00,
        FLQT_ANSWER = 2'b01
    } flqt_phase_e;
endpackage

// File: logic/flqt_rom.sv
// Purpose: fixed query word lookup by location index
// Assumes: location index is 7 bits
// Notes:   purely combinational; undefined locations give zero and no hit
`timescale 1ns/1ps
`include "flqt_map.svh"
module flqt_rom
(
    input  wire logic [6:0]         loc,   // query location index
    output flqt_pkg::flqt_word_t    word,  // word at that location
    output logic                    hit    // location belongs to the table
);
    // table contents, upper byte always zero
    always_comb
    begin
        hit  = 1'b1;
        word = `FLQT_VAL_ZERO;
        case (loc)
            `FLQT_LOC_PTR_LO:     word = `FLQT_VAL_PTR_LO;     // R13
            `FLQT_LOC_PTR_HI:     word = `FLQT_VAL_ZERO;       // R13
            `FLQT_LOC_ID_P:       word = `FLQT_VAL_ID_P;       // R14
            `FLQT_LOC_ID_R:       word = `FLQT_VAL_ID_R;       // R14
            `FLQT_LOC_ID_I:       word = `FLQT_VAL_ID_I;       // R14
            `FLQT_LOC_MAJOR:      word = `FLQT_VAL_MAJOR;      // R1
            `FLQT_LOC_MINOR:      word = `FLQT_VAL_MINOR;      // R2
            `FLQT_LOC_FEAT0:      word = `FLQT_VAL_FEAT0;      // R3 R4
            `FLQT_LOC_FEAT1:      word = `FLQT_VAL_FEAT1;      // R3 R4
            `FLQT_LOC_FEAT2:      word = `FLQT_VAL_ZERO;       // R5
            `FLQT_LOC_FEAT3:      word = `FLQT_VAL_ZERO;       // R5
            `FLQT_LOC_SUSP:       word = `FLQT_VAL_SUSP;       // R6
            `FLQT_LOC_PROT_LO:    word = `FLQT_VAL_PROT_LO;    // R7
            `FLQT_LOC_PROT_HI:    word = `FLQT_VAL_ZERO;       // R7
            `FLQT_LOC_VDD_OPT:    word = `FLQT_VAL_VDD_OPT;    // R8
            `FLQT_LOC_VPP_OPT:    word = `FLQT_VAL_VPP_OPT;    // R9
            `FLQT_LOC_PR_COUNT:   word = `FLQT_VAL_PR_COUNT;   // R10
            `FLQT_LOC_PR_ADDR_LO: word = `FLQT_VAL_PR_ADDR_LO; // R11
            `FLQT_LOC_PR_ADDR_HI: word = `FLQT_VAL_ZERO;       // R11
            `FLQT_LOC_PR_FACT:    word = `FLQT_VAL_PR_FACT;    // R12
            `FLQT_LOC_PR_USER:    word = `FLQT_VAL_PR_USER;    // R12
            default:              hit  = 1'b0;                 // R15
        endcase
    end
endmodule

// File: logic/flqt_top.sv
// Purpose: apb slave that serves the extended query table of a flash device
// Assumes: single clock pclk, asynchronous active-low presetn, apb4 master
// Notes:   zero wait states; data and response come from flip-flops
`timescale 1ns/1ps
`include "flqt_map.svh"

// Behaviour
// R1: location 3Ch reads major version 0031h
// R2: location 3Dh reads minor version 0030h
// R3: feature field 3Eh=00E6h, 3Fh=0003h, low first
// R4: feature flags one when present, bit order fixed
// R5: feature bits 10 to 31 read zero
// R6: location 42h reads 0001h, program after suspend
// R7: 43h reads 0003h, 44h reads 0000h
// R8: location 45h reads 0018h, logic supply 1.8V
// R9: location 46h reads 00C0h, program supply 12V
// R10: location 47h reads 0001h protection field count
// R11: protection address low then high forms 0080h
// R12: factory exponent 0003h, user exponent 0004h
// R13: pointer at 15h gives table base 39h
// R14: table starts 39h with ascii P R I
// R15: each word carries byte low, upper zero
module flqt_top
#(
    parameter int CNT_W = 16                   // width of the table read counter
)
(
    input  wire logic        pclk,             // bus clock, 25 MHz
    input  wire logic        presetn,          // asynchronous reset, active low
    input  wire logic        psel,             // slave select
    input  wire logic        penable,          // access phase
    input  wire logic        pwrite,           // write when high
    input  wire logic [11:0] paddr,            // byte address
    input  wire logic [31:0] pwdata,           // write data
    input  wire logic [3:0]  pstrb,            // write byte strobes
    output logic      [31:0] prdata,           // read data, registered
    output logic             pready,           // transfer completes, registered
    output logic             pslverr,          // error response, registered
    output logic             query_mode        // query mode is active, registered
);

    flqt_pkg::flqt_apb_req_s req;               // bundled request
    flqt_pkg::flqt_phase_e   phase;             // transfer phase
    flqt_pkg::flqt_phase_e   next_phase;        // next transfer phase
    flqt_pkg::flqt_word_t    rom_word;          // looked-up query word
    logic                    rom_hit;           // location belongs to the table
    logic                    setup;             // setup cycle of any transfer
    logic                    in_query;          // address falls in query window
    logic                    is_ctrl;           // address hits control register
    logic                    is_stat;           // address hits status register
    logic                    bad;               // this transfer answers with error
    logic [31:0]             next_rdata;        // read data for this transfer
    logic [CNT_W-1:0]        read_count;        // successful table reads

    // collect the bus into one request
    assign req = '{sel: psel, en: penable, wr: pwrite, addr: paddr, wdata: pwdata, strb: pstrb};

    // setup cycle: psel high, penable low
    assign setup = req.sel && !req.en;

    // address decode
    assign in_query = (req.addr <= `FLQT_QUERY_TOP) && (req.addr[1:0] == 2'b00);
    assign is_ctrl  = (req.addr == `FLQT_ADDR_CTRL);
    assign is_stat  = (req.addr == `FLQT_ADDR_STAT);

    // table lookup on the word index of the address
    flqt_rom u_rom
    (
        .loc  (req.addr[8:2]),
        .word (rom_word),
        .hit  (rom_hit)
    );

    // error: table written, table read outside query mode, status written, unmapped
    always_comb
    begin
        bad = 1'b0;
        if (in_query)
        begin
            // table is read only and visible only in query mode
            bad = req.wr || !query_mode;
        end
        else if (is_stat)
        begin
            // status is read only
            bad = req.wr;
        end
        else if (!is_ctrl)
        begin
            // nothing lives here
            bad = 1'b1;
        end
    end

    // read data mux, zero on any error or write
    always_comb
    begin
        next_rdata = 32'h0000_0000;
        if (!req.wr && !bad)
        begin
            if (in_query)
            begin
                // undefined query locations read zero
                next_rdata = rom_hit ? {16'h0000, rom_word} : 32'h0000_0000; // R15
            end
            else if (is_ctrl)
            begin
                // control register: query enable in bit 0
                next_rdata[`FLQT_CTRL_QEN_BIT] = query_mode;
            end
            else
            begin
                // status: read counter and mode mirror
                next_rdata[CNT_W-1:0] = read_count;
                next_rdata[`FLQT_STAT_QEN_BIT] = query_mode;
            end
        end
    end

    // phase sequencing: answer in the cycle after setup
    always_comb
    begin
        next_phase = flqt_pkg::FLQT_IDLE;
        case (phase)
            flqt_pkg::FLQT_IDLE:
            begin
                // a setup cycle moves to answer
                if (setup)
                begin
                    next_phase = flqt_pkg::FLQT_ANSWER;
                end
            end
            flqt_pkg::FLQT_ANSWER:
            begin
                // access phase completes, back to idle
                next_phase = flqt_pkg::FLQT_IDLE;
            end
            default:
            begin
                // illegal code recovers to idle
                next_phase = flqt_pkg::FLQT_IDLE;
            end
        endcase
    end

    // phase register
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            phase <= flqt_pkg::FLQT_IDLE;
        end
        else
        begin
            phase <= next_phase;
        end
    end

    // ready and response, raised for the one access cycle
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end
        else if (phase == flqt_pkg::FLQT_IDLE && setup)
        begin
            // answer is ready at the first access cycle
            pready  <= 1'b1;
            pslverr <= bad;
        end
        else
        begin
            // drop after the completing edge
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end
    end

    // read data, captured in the setup cycle and held through access
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata <= 32'h0000_0000;
        end
        else if (phase == flqt_pkg::FLQT_IDLE && setup)
        begin
            prdata <= next_rdata;
        end
    end

    // control register: query mode enable, written at the completing edge
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            query_mode <= `FLQT_CTRL_RESET;
        end
        else if (req.sel && req.en && pready && req.wr && is_ctrl && req.strb[0])
        begin
            query_mode <= req.wdata[`FLQT_CTRL_QEN_BIT];
        end
    end

    // count table reads that complete without error
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            read_count <= '0;
        end
        else if (req.sel && req.en && pready && !pslverr && !req.wr && in_query)
        begin
            read_count <= read_count + 1'b1;
        end
    end

    // byte address of a query location
    function automatic flqt_pkg::flqt_addr_t loc_addr(input logic [6:0] l);
        loc_addr = {3'h0, l, 2'b00};
    endfunction

    // table read in query mode at a given location
    sequence s_qread(logic [6:0] l);
        setup && !req.wr && query_mode && (phase == flqt_pkg::FLQT_IDLE) && (req.addr == loc_addr(l));
    endsequence

    // answer carrying a given word
    sequence s_word(logic [15:0] v);
        pready && !pslverr && (prdata == {16'h0000, v});
    endsequence

    property p_loc(logic [6:0] l, logic [15:0] v);
        @(posedge pclk) disable iff (!presetn)
        s_qread(l) |=> s_word(v);
    endproperty

    a_major_version: assert property (p_loc(`FLQT_LOC_MAJOR, `FLQT_VAL_MAJOR)) // R1
        else $error("major version word wrong");
    a_minor_version: assert property (p_loc(`FLQT_LOC_MINOR, `FLQT_VAL_MINOR)) // R2
        else $error("minor version word wrong");
    a_feature_low: assert property (p_loc(`FLQT_LOC_FEAT0, `FLQT_VAL_FEAT0)) // R3
        else $error("feature low byte wrong");
    a_feature_next: assert property (p_loc(`FLQT_LOC_FEAT1, `FLQT_VAL_FEAT1)) // R3
        else $error("feature second byte wrong");
    a_feature_flags: assert property (@(posedge pclk) disable iff (!presetn) // R4
        s_qread(`FLQT_LOC_FEAT1) |=> (prdata[1:0] == 2'b11) && (prdata[31:2] == 30'h0))
        else $error("feature flags 8 and 9 wrong");
    a_feature_upper: assert property (@(posedge pclk) disable iff (!presetn) // R5
        (s_qread(`FLQT_LOC_FEAT2) or s_qread(`FLQT_LOC_FEAT3)) |=> pready && (prdata == 32'h0))
        else $error("reserved feature bits not zero");
    a_suspend_funcs: assert property (p_loc(`FLQT_LOC_SUSP, `FLQT_VAL_SUSP)) // R6
        else $error("suspend functions word wrong");
    a_protect_status: assert property (@(posedge pclk) disable iff (!presetn) // R7
        s_qread(`FLQT_LOC_PROT_LO) |=> s_word(`FLQT_VAL_PROT_LO) ##1 !pready)
        else $error("block protect status wrong");
    a_protect_high: assert property (p_loc(`FLQT_LOC_PROT_HI, `FLQT_VAL_ZERO)) // R7
        else $error("block protect high word wrong");
    a_vdd_optimum: assert property (p_loc(`FLQT_LOC_VDD_OPT, `FLQT_VAL_VDD_OPT)) // R8
        else $error("logic supply word wrong");
    a_vpp_optimum: assert property (p_loc(`FLQT_LOC_VPP_OPT, `FLQT_VAL_VPP_OPT)) // R9
        else $error("program supply word wrong");
    a_prot_count: assert property (p_loc(`FLQT_LOC_PR_COUNT, `FLQT_VAL_PR_COUNT)) // R10
        else $error("protection field count wrong");
    a_prot_addr: assert property (@(posedge pclk) disable iff (!presetn) // R11
        (s_qread(`FLQT_LOC_PR_ADDR_LO) |=> s_word(`FLQT_VAL_PR_ADDR_LO))
        and (s_qread(`FLQT_LOC_PR_ADDR_HI) |=> s_word(`FLQT_VAL_ZERO)))
        else $error("protection register address wrong");
    a_prot_sizes: assert property (@(posedge pclk) disable iff (!presetn) // R12
        (s_qread(`FLQT_LOC_PR_FACT) |=> s_word(`FLQT_VAL_PR_FACT))
        and (s_qread(`FLQT_LOC_PR_USER) |=> s_word(`FLQT_VAL_PR_USER)))
        else $error("protection region sizes wrong");
    a_base_pointer: assert property (p_loc(`FLQT_LOC_PTR_LO, `FLQT_VAL_PTR_LO)) // R13
        else $error("table base pointer wrong");
    a_id_string: assert property (@(posedge pclk) disable iff (!presetn) // R14
        (s_qread(`FLQT_LOC_ID_P) |=> s_word(`FLQT_VAL_ID_P))
        and (s_qread(`FLQT_LOC_ID_R) |=> s_word(`FLQT_VAL_ID_R))
        and (s_qread(`FLQT_LOC_ID_I) |=> s_word(`FLQT_VAL_ID_I)))
        else $error("table id string wrong");
    a_upper_zero: assert property (@(posedge pclk) disable iff (!presetn) // R15
        (setup && in_query && (phase == flqt_pkg::FLQT_IDLE)) |=> pready && (prdata[31:16] == 16'h0))
        else $error("query word upper half not zero");
    a_closed_table: assert property (@(posedge pclk) disable iff (!presetn)
        (setup && in_query && !query_mode && (phase == flqt_pkg::FLQT_IDLE)) |=> pready && pslverr)
        else $error("table answered outside query mode");
endmodule

// File: verification/flqt_host.sv
// Purpose: apb master that stands for the host memory controller
// Assumes: tasks are entered just after a rising edge of pclk
// Notes:   a wait for pready that reaches 16 edges raises hung and goes on until pready arrives or the bench watchdog ends it
`timescale 1ns/1ps
module flqt_host
(
    input  wire logic        pclk,     // bus clock
    input  wire logic        pready,   // slave answer
    output logic             psel,     // slave select
    output logic             penable,  // access phase
    output logic             pwrite,   // write when high
    output logic [11:0]      paddr,    // byte address
    output logic [31:0]      pwdata,   // write data
    output logic [3:0]       pstrb,    // byte strobes
    output logic             hung      // no answer within 16 edges
);
    // bus idle from time zero
    initial
    begin
        psel    = 1'b0;
        penable = 1'b0;
        pwrite  = 1'b0;
        paddr   = 12'h000;
        pwdata  = 32'h0000_0000;
        pstrb   = 4'h0;
        hung    = 1'b0;
    end

    // one transfer: setup, then access held until pready is sampled high
    task xfer(input logic wr, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
        int n;
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        pstrb   <= s;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge pclk);
            n++;
            // flag a slow answer but keep holding the request
            if (n == 16)
                hung <= 1'b1;
        end
        while (pready !== 1'b1);
    endtask

    // drop the request; released address and write data show the inverse so stale values never match
    task release_bus();
        psel    <= 1'b0;
        penable <= 1'b0;
        paddr   <= ~paddr;
        pwdata  <= ~pwdata;
        @(posedge pclk);
    endtask
endmodule

// File: verification/tb_top.sv
// Purpose: self-checking bench for the query table slave
// Assumes: host model drives apb; expected answers queue up in request order
// Notes:   a monitor pops one note per completed transfer
`timescale 1ns/1ps
`include "flqt_map.svh"
module tb_top;
    logic        pclk;        // 25 MHz clock
    logic        presetn;     // reset, active low
    logic        psel;        // apb select
    logic        penable;     // apb access
    logic        pwrite;      // apb direction
    logic [11:0] paddr;       // apb address
    logic [31:0] pwdata;      // apb write data
    logic [3:0]  pstrb;       // apb strobes
    logic [31:0] prdata;      // read data
    logic        pready;      // transfer done
    logic        pslverr;     // error answer
    logic        query_mode;  // query mode level
    logic        hung;        // host saw no answer in 16 edges
    logic [32:0] exp_q[$];    // expected {error, data}
    logic [15:0] reads;       // error-free table reads so far
    logic [7:0]  lfsr;        // random source
    logic        qm;          // expected query mode
    logic [6:0]  base;        // table base from the pointer
    int          err_total;   // mismatches
    int          checked;     // comparisons

    // clock
    initial
        pclk = 1'b0;
    always #20 pclk = ~pclk;

    flqt_top i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .query_mode(query_mode));
    flqt_host i_host (.pclk(pclk), .pready(pready), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .hung(hung));

    // compare seen against expected
    task automatic check(input logic [32:0] seen, input logic [32:0] exp);
        checked++;
        if (seen !== exp)
        begin
            err_total++;
            $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask

    // verdict and end of run
    task stop_test();
        $display("checks %0d mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // eight-bit shift register step
    function automatic logic [7:0] next_lfsr(input logic [7:0] v);
        return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
    endfunction

    // expected byte of each query location
    function automatic logic [15:0] exp_loc(input logic [6:0] l);
        case (l)
            7'h15: return 16'h0039;
            7'h39: return 16'h0050;
            7'h3a: return 16'h0052;
            7'h3b: return 16'h0049;
            7'h3c: return 16'h0031;
            7'h3d: return 16'h0030;
            7'h3e: return 16'h00e6;
            7'h3f: return 16'h0003;
            7'h42: return 16'h0001;
            7'h43: return 16'h0003;
            7'h45: return 16'h0018;
            7'h46: return 16'h00c0;
            7'h47: return 16'h0001;
            7'h48: return 16'h0080;
            7'h4a: return 16'h0003;
            7'h4b: return 16'h0004;
            default: return 16'h0000;
        endcase
    endfunction

    // queued read and write
    task rd(input logic [11:0] a, input logic [32:0] e);
        exp_q.push_back(e);
        i_host.xfer(1'b0, a, 32'h0000_0000, 4'h0);
    endtask
    task wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s, input logic e);
        exp_q.push_back({e, 32'h0000_0000});
        i_host.xfer(1'b1, a, d, s);
    endtask
    // table read, refused while query mode is off
    task rdloc(input logic [6:0] l);
        rd({3'b000, l, 2'b00}, qm ? {17'h0_0000, exp_loc(l)} : {1'b1, 32'h0000_0000});
        if (qm)
            reads++;
    endtask

    // monitor: every completed transfer takes the oldest note
    always @(posedge pclk)
    begin
        if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1)
        begin
            if (exp_q.size() == 0)
                check({pslverr, prdata}, 33'h1_ffff_ffff);
            else
                check({pslverr, prdata}, exp_q.pop_front());
        end
    end

    // watchdog
    initial
    begin
        #(40 * 20000);
        err_total++;
        stop_test();
    end

    // main sequence
    initial
    begin
        presetn = 1'b0;
        qm = 1'b0;
        reads = 16'h0000;
        lfsr = 8'h3f;
        err_total = 0;
        checked = 0;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        check({32'h0, query_mode}, 33'h0);
        rdloc(7'h3c);
        rd(`FLQT_ADDR_STAT, 33'h0);
        wr(`FLQT_ADDR_CTRL, 32'h1, 4'h0, 1'b0);
        i_host.release_bus();
        check({32'h0, query_mode}, 33'h0);
        wr(`FLQT_ADDR_CTRL, 32'h1, 4'h1, 1'b0);
        i_host.release_bus();
        qm = 1'b1;
        check({32'h0, query_mode}, 33'h1);
        rd(`FLQT_ADDR_CTRL, 33'h1);
        rdloc(`FLQT_LOC_PTR_LO);
        base = 7'(`FLQT_VAL_PTR_LO);
        for (int i = 0; i < 19; i++)
            rdloc(base + 7'(i));
        rdloc(`FLQT_LOC_PTR_HI);
        repeat (40)
        begin
            lfsr = next_lfsr(lfsr);
            rdloc(lfsr[6:0]);
        end
        rd(`FLQT_ADDR_STAT, {17'h0_0001, reads});
        wr(12'h0f0, {24'h0, lfsr}, 4'hf, 1'b1);
        rd(12'h0f2, 33'h1_0000_0000);
        rd(12'h200, 33'h1_0000_0000);
        wr(`FLQT_ADDR_STAT, 32'h0, 4'hf, 1'b1);
        rd(`FLQT_ADDR_STAT, {17'h0_0001, reads});
        wr(`FLQT_ADDR_CTRL, 32'h0, 4'h1, 1'b0);
        qm = 1'b0;
        rdloc(7'h45);
        i_host.release_bus();
        check({32'h0, query_mode}, 33'h0);
        wr(`FLQT_ADDR_CTRL, 32'h1, 4'h1, 1'b0);
        i_host.release_bus();
        presetn <= 1'b0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        reads = 16'h0000;
        check({32'h0, query_mode}, 33'h0);
        rd(`FLQT_ADDR_STAT, 33'h0);
        i_host.release_bus();
        check({32'h0, hung}, 33'h0);
        stop_test();
    end
endmodule
